// ---- logic/lcd_pkg.sv ----
// constants for the lvds/cmos channel divider block
package lcd_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] LCD_IDX_S1_CNT   = 10'h199;
  localparam logic [9:0] LCD_IDX_PHASE    = 10'h19A;
  localparam logic [9:0] LCD_IDX_S2_CNT   = 10'h19B;
  localparam logic [9:0] LCD_IDX_CTRL     = 10'h19C;
  localparam logic [9:0] LCD_IDX_DCC      = 10'h19D;
  localparam logic [9:0] LCD_IDX_NXT_CNT  = 10'h19E;
  localparam logic [9:0] LCD_IDX_STATUS   = 10'h1B0;

  localparam int LCD_ADDR_W = 12;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LCD_LOW_LSB      = 4;
  localparam int LCD_HIGH_LSB     = 0;
  localparam int LCD_PH2_LSB      = 4;
  localparam int LCD_PH1_LSB      = 0;
  localparam int LCD_BIT_BYP2     = 5;
  localparam int LCD_BIT_BYP1     = 4;
  localparam int LCD_BIT_NOSYNC   = 3;
  localparam int LCD_BIT_FORCE    = 2;
  localparam int LCD_BIT_START2   = 1;
  localparam int LCD_BIT_START1   = 0;
  localparam int LCD_BIT_DCC_DIS  = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LCD_RST_S1_CNT  = 8'h00;
  localparam logic [7:0] LCD_RST_PHASE   = 8'h00;
  localparam logic [7:0] LCD_RST_S2_CNT  = 8'h00;
  localparam logic [7:0] LCD_RST_CTRL    = 8'h00;
  localparam logic [7:0] LCD_RST_DCC     = 8'h00;
  localparam logic [7:0] LCD_RST_NXT_CNT = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int LCD_CNT_W    = 5;
  localparam int LCD_PERIOD_W = 11;

endpackage : lcd_pkg

// ---- logic/lcd_stage.sv ----
// one programmable divider stage counting input clock ticks
`timescale 1ns/1ns
`default_nettype none
module lcd_stage
  import lcd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       in_tick,
  input  wire logic       in_level,
  input  wire logic       bypass,
  input  wire logic [3:0] low_cnt,
  input  wire logic [3:0] high_cnt,
  input  wire logic [3:0] phase,
  input  wire logic       start_high,
  input  wire logic       restart,
  input  wire logic       hold,
  output logic            out_level,
  output logic            out_tick
);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic                 lvl_q;
  logic                 lvl_d;
  logic [LCD_CNT_W-1:0] cnt_q;
  logic [LCD_CNT_W-1:0] cnt_d;
  wire  [LCD_CNT_W-1:0] start_load;
  wire  [LCD_CNT_W-1:0] low_load;
  wire  [LCD_CNT_W-1:0] high_load;
  wire                  expire;
  wire                  run;

  assign low_load   = {1'b0, low_cnt};
  assign high_load  = {1'b0, high_cnt};
  // first phase after a restart is stretched by the offset
  assign start_load = (start_high ? high_load : low_load) + {1'b0, phase}; // RULE5 RULE15
  assign run        = in_tick && !bypass && !hold;
  assign expire     = run && (cnt_q == '0);

  always_comb begin
    lvl_d = lvl_q;
    cnt_d = cnt_q;
    if (bypass) begin
      // divider powered down: counter parked, input passes through
      lvl_d = in_level; // RULE6 RULE7
      cnt_d = start_load;
    end else if (restart || hold) begin
      lvl_d = start_high; // RULE11 RULE12 RULE15
      cnt_d = start_load;
    end else if (expire) begin
      lvl_d = !lvl_q;
      cnt_d = lvl_q ? low_load : high_load; // RULE1 RULE2 RULE3 RULE4
    end else if (run) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  assign out_level = lvl_q;
  assign out_tick  = bypass ? in_tick : (expire && !lvl_q);

endmodule : lcd_stage
`default_nettype wire

// ---- logic/lcd_duty.sv ----
// duty-cycle correction of the divided channel output
`timescale 1ns/1ns
`default_nettype none
module lcd_duty
  import lcd_pkg::*;
#(
  parameter int PERIOD_W = LCD_PERIOD_W
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic rise_tick,
  input  wire logic level_in,
  input  wire logic enable,
  output logic      level_out
);

  initial begin
    if (PERIOD_W < 4) $error("lcd_duty: PERIOD_W too small");
  end

  logic [PERIOD_W-1:0] cnt_q;
  logic [PERIOD_W-1:0] period_q;
  logic                corr_q;
  wire                 measured;
  wire [PERIOD_W-1:0]  half;
  wire [PERIOD_W-1:0]  cnt_inc;

  assign cnt_inc  = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
  assign half     = period_q >> 1;
  assign measured = period_q > {{(PERIOD_W-2){1'b0}}, 2'b10};

  // measure period in input ticks and rebuild a half-period high phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      period_q <= '0;
      corr_q   <= 1'b0;
    end else if (tick) begin
      if (rise_tick) begin
        period_q <= cnt_inc;
        cnt_q    <= '0;
        corr_q   <= 1'b1;
      end else begin
        cnt_q <= cnt_inc;
        if (cnt_inc >= half) corr_q <= 1'b0;
      end
    end
  end

  // correction only once a period wider than two ticks is known
  assign level_out = (enable && measured) ? corr_q : level_in; // RULE13

endmodule : lcd_duty
`default_nettype wire

// ---- logic/lcd_channel_divider.sv ----
// lvds/cmos channel divider: two cascaded stages, next-channel stage, apb registers
//
// What this block does
// [RULE1] stage one output stays low for low field plus one input cycles
// [RULE2] stage one output stays high for high field plus one input cycles
// [RULE3] stage two low and high phases last their fields plus one cycles
// [RULE4] next channel's first stage low and high last their fields plus one
// [RULE5] four-bit phase offset per stage; stage two upper nibble, one lower
// [RULE6] stage two bypass powers down its divider and passes its input
// [RULE7] stage one bypass powers down its divider and passes its input
// [RULE8] sync-ignore zero obeys chip sync; one disregards it
// [RULE9] force bit sets static forced output level, one high, zero low
// [RULE10] software sets sync-ignore too when it wants a forced level
// [RULE11] stage two start polarity chooses initial output level
// [RULE12] stage one start polarity chooses initial output level
// [RULE13] duty correction active while disable bit is zero
// [RULE14] stage two is clocked by stage one output; divisions multiply
// [RULE15] honoured sync restarts each stage at start level with offset
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
module lcd_channel_divider
  import lcd_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [LCD_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  dist_tick,
  input  wire logic                  dist_level,
  input  wire logic                  sync_n,
  output logic                       stage1_level,
  output logic                       stage2_level,
  output logic                       channel_level,
  output logic                       channel_tick,
  output logic                       next_stage1_level
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [LCD_ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a[LCD_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  wire setup   = psel && !penable;
  wire wr_en   = psel && penable && pwrite;
  wire sel_s1  = hit(paddr, LCD_IDX_S1_CNT);
  wire sel_ph  = hit(paddr, LCD_IDX_PHASE);
  wire sel_s2  = hit(paddr, LCD_IDX_S2_CNT);
  wire sel_ct  = hit(paddr, LCD_IDX_CTRL);
  wire sel_dc  = hit(paddr, LCD_IDX_DCC);
  wire sel_nx  = hit(paddr, LCD_IDX_NXT_CNT);
  wire sel_st  = hit(paddr, LCD_IDX_STATUS);
  wire sel_rw  = sel_s1 || sel_ph || sel_s2 || sel_ct || sel_dc || sel_nx;
  wire mapped  = sel_rw || sel_st;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] s1_cnt_q;
  logic [7:0] phase_q;
  logic [7:0] s2_cnt_q;
  logic [7:0] ctrl_q;
  logic [7:0] dcc_q;
  logic [7:0] nxt_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_cnt_q  <= LCD_RST_S1_CNT;
      phase_q   <= LCD_RST_PHASE;
      s2_cnt_q  <= LCD_RST_S2_CNT;
      ctrl_q    <= LCD_RST_CTRL;
      dcc_q     <= LCD_RST_DCC;
      nxt_cnt_q <= LCD_RST_NXT_CNT;
    end else if (wr_en) begin
      if (sel_s1) s1_cnt_q  <= pwdata[7:0];
      if (sel_ph) phase_q   <= pwdata[7:0];
      if (sel_s2) s2_cnt_q  <= pwdata[7:0];
      if (sel_ct) ctrl_q    <= {2'b00, pwdata[5:0]};
      if (sel_dc) dcc_q     <= {7'h00, pwdata[0]};
      if (sel_nx) nxt_cnt_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  wire [3:0] s1_low   = s1_cnt_q[LCD_LOW_LSB +: 4];
  wire [3:0] s1_high  = s1_cnt_q[LCD_HIGH_LSB +: 4];
  wire [3:0] s2_low   = s2_cnt_q[LCD_LOW_LSB +: 4];
  wire [3:0] s2_high  = s2_cnt_q[LCD_HIGH_LSB +: 4];
  wire [3:0] nx_low   = nxt_cnt_q[LCD_LOW_LSB +: 4];
  wire [3:0] nx_high  = nxt_cnt_q[LCD_HIGH_LSB +: 4];
  wire [3:0] ph2      = phase_q[LCD_PH2_LSB +: 4]; // RULE5
  wire [3:0] ph1      = phase_q[LCD_PH1_LSB +: 4]; // RULE5
  wire       byp2     = ctrl_q[LCD_BIT_BYP2];
  wire       byp1     = ctrl_q[LCD_BIT_BYP1];
  wire       nosync   = ctrl_q[LCD_BIT_NOSYNC];
  wire       force_hi = ctrl_q[LCD_BIT_FORCE];
  wire       start2   = ctrl_q[LCD_BIT_START2];
  wire       start1   = ctrl_q[LCD_BIT_START1];
  wire       dcc_dis  = dcc_q[LCD_BIT_DCC_DIS];

  // ----------------------------------------------------------------
  // chip sync pin: synchroniser and release detect
  // ----------------------------------------------------------------
  logic sync_s1_q;
  logic sync_s2_q;
  logic held_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_s1_q <= 1'b1;
      sync_s2_q <= 1'b1;
      held_q    <= 1'b0;
    end else begin
      sync_s1_q <= sync_n;
      sync_s2_q <= sync_s1_q;
      held_q    <= !sync_s2_q;
    end
  end

  wire sync_held = !sync_s2_q;
  wire release_p = held_q && !sync_held;
  // sync only reaches the stages while it is not ignored
  wire hold_div  = sync_held && !nosync;  // RULE8
  wire restart   = release_p && !nosync;  // RULE8 RULE15
  // with sync ignored a held sync parks the output at the forced level
  wire forcing   = sync_held && nosync;   // RULE9 RULE10

  // ----------------------------------------------------------------
  // stage one, stage two, next channel stage one
  // ----------------------------------------------------------------
  logic s1_lvl;
  logic s1_tick;
  logic s2_lvl;
  logic s2_tick;
  logic nx_lvl;

  lcd_stage u_stage1 (
    .clk        (pclk),
    .rst_n      (presetn),
    .in_tick    (dist_tick),
    .in_level   (dist_level),
    .bypass     (byp1),
    .low_cnt    (s1_low),
    .high_cnt   (s1_high),
    .phase      (ph1),
    .start_high (start1),
    .restart    (restart),
    .hold       (hold_div),
    .out_level  (s1_lvl),
    .out_tick   (s1_tick)
  );

  // stage two counts periods of stage one
  lcd_stage u_stage2 (
    .clk        (pclk),
    .rst_n      (presetn),
    .in_tick    (s1_tick),  // RULE14
    .in_level   (s1_lvl),   // RULE14
    .bypass     (byp2),
    .low_cnt    (s2_low),
    .high_cnt   (s2_high),
    .phase      (ph2),
    .start_high (start2),
    .restart    (restart),
    .hold       (hold_div),
    .out_level  (s2_lvl),
    .out_tick   (s2_tick)
  );

  lcd_stage u_next_stage1 (
    .clk        (pclk),
    .rst_n      (presetn),
    .in_tick    (dist_tick),
    .in_level   (dist_level),
    .bypass     (1'b0),
    .low_cnt    (nx_low),
    .high_cnt   (nx_high),
    .phase      (4'h0),
    .start_high (1'b0),
    .restart    (restart),
    .hold       (hold_div),
    .out_level  (nx_lvl),
    .out_tick   ()
  );

  // ----------------------------------------------------------------
  // duty correction and output select
  // ----------------------------------------------------------------
  logic dcc_lvl;

  lcd_duty #(
    .PERIOD_W (LCD_PERIOD_W)
  ) u_duty (
    .clk       (pclk),
    .rst_n     (presetn),
    .tick      (dist_tick),
    .rise_tick (s2_tick),
    .level_in  (s2_lvl),
    .enable    (!dcc_dis),  // RULE13
    .level_out (dcc_lvl)
  );

  wire chan_d = forcing ? force_hi : dcc_lvl; // RULE9

  logic chan_q;
  logic chan_tick_q;
  logic s1_q;
  logic s2_q;
  logic nx_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q      <= 1'b0;
      chan_tick_q <= 1'b0;
      s1_q        <= 1'b0;
      s2_q        <= 1'b0;
      nx_q        <= 1'b0;
    end else begin
      chan_q      <= chan_d;
      chan_tick_q <= s2_tick && !forcing;
      s1_q        <= s1_lvl;
      s2_q        <= s2_lvl;
      nx_q        <= nx_lvl;
    end
  end

  assign channel_level     = chan_q;
  assign channel_tick      = chan_tick_q;
  assign stage1_level      = s1_q;
  assign stage2_level      = s2_q;
  assign next_stage1_level = nx_q;

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  wire [7:0] status = {2'b00, !dcc_dis, sync_held, nx_q, s2_q, s1_q, chan_q};
  wire [7:0] rd_mux =
    sel_s1 ? s1_cnt_q  :
    sel_ph ? phase_q   :
    sel_s2 ? s2_cnt_q  :
    sel_ct ? ctrl_q    :
    sel_dc ? dcc_q     :
    sel_nx ? nxt_cnt_q :
    sel_st ? status    : 8'h00;

  logic [31:0] prdata_q;
  logic        err_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_mux};
      err_q    <= !mapped || (pwrite && sel_st);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_q;

endmodule : lcd_channel_divider
`default_nettype wire

// ---- testbench/lcd_channel_divider_asserts.sv ----
// concurrent checks on the channel divider ports
`timescale 1ns/1ns
`default_nettype none
module lcd_channel_divider_asserts
  import lcd_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic [LCD_ADDR_W-1:0] paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  sync_n,
  input wire logic                  stage1_level,
  input wire logic                  stage2_level,
  input wire logic                  channel_level,
  input wire logic                  channel_tick,
  input wire logic                  next_stage1_level
);
  localparam int CALM = 600;
  // ----
  // shadow registers and run-length counters
  // ----
  logic [7:0] s1_q, s2_q, nx_q;
  logic [5:0] ct_q;
  logic       dd_q;
  logic [9:0] calm_q;
  logic [3:0] slo_q;
  logic [3:0] lv_q;
  logic [9:0] run_q [4];
  wire        wr   = psel && penable && pwrite && pready;
  wire [3:0]  lv   = {next_stage1_level, channel_level, stage2_level, stage1_level};
  wire        calm = calm_q > CALM;
  wire [9:0]  p1   = 10'(s1_q[7:4]) + 10'(s1_q[3:0]) + 10'h2;
  wire [9:0]  l2   = 10'(s2_q[7:4]) + 10'h1;
  wire [9:0]  h2   = 10'(s2_q[3:0]) + 10'h1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {s1_q, s2_q, nx_q, ct_q, dd_q} <= '0;
      {calm_q, slo_q, lv_q} <= '0;
      for (int i = 0; i < 4; i++) run_q[i] <= 10'h000;
    end else begin
      if (wr && paddr == {LCD_IDX_S1_CNT, 2'b00}) s1_q <= pwdata[7:0];
      if (wr && paddr == {LCD_IDX_S2_CNT, 2'b00}) s2_q <= pwdata[7:0];
      if (wr && paddr == {LCD_IDX_NXT_CNT, 2'b00}) nx_q <= pwdata[7:0];
      if (wr && paddr == {LCD_IDX_CTRL, 2'b00}) ct_q <= pwdata[5:0];
      if (wr && paddr == {LCD_IDX_DCC, 2'b00}) dd_q <= pwdata[0];
      calm_q <= (wr || !sync_n) ? 10'h000 : calm_q + 10'(calm_q != 10'h3FF);
      slo_q <= sync_n ? 4'h0 : slo_q + 4'(slo_q != 4'hF);
      lv_q <= lv;
      for (int i = 0; i < 4; i++) run_q[i] <= (lv[i] != lv_q[i]) ? 10'h001 : run_q[i] + 10'h001;
    end
  end
  a_s1_low_run : assert property (
    calm && !ct_q[4] && $rose(stage1_level) |-> run_q[0] == 10'(s1_q[7:4]) + 10'h1)
    else $error("stage one low run wrong");
  a_s1_high_run : assert property (
    calm && !ct_q[4] && $fell(stage1_level) |-> run_q[0] == 10'(s1_q[3:0]) + 10'h1)
    else $error("stage one high run wrong");
  a_s2_cascade_run : assert property (
    calm && ct_q[5:4] == 2'b00 && $changed(stage2_level) |-> run_q[1] == (stage2_level ? l2 : h2) * p1)
    else $error("stage two run wrong");
  a_next_stage_run : assert property (
    calm && $changed(next_stage1_level) |->
      run_q[3] == 10'(next_stage1_level ? nx_q[7:4] : nx_q[3:0]) + 10'h1)
    else $error("next channel stage run wrong");
  a_byp1_pass : assert property (
    calm && ct_q[4] |-> $changed(stage1_level))
    else $error("stage one bypass does not pass input");
  a_byp2_pass : assert property (
    calm && ct_q[5:4] == 2'b10 && $changed(stage2_level) |->
      run_q[1] == 10'(stage2_level ? s1_q[7:4] : s1_q[3:0]) + 10'h1)
    else $error("stage two bypass does not follow stage one");
  a_sync_start_hold : assert property (
    !ct_q[3] && ct_q[5:4] == 2'b00 && slo_q > 4'h7 |-> stage1_level == ct_q[0] && stage2_level == ct_q[1])
    else $error("stages not held at start level during sync");
  a_force_level : assert property (
    ct_q[3] && slo_q > 4'h7 |-> channel_level == ct_q[2])
    else $error("forced channel level wrong");
  a_dcc_off_run : assert property (
    calm && dd_q && ct_q[5:4] == 2'b00 && $changed(channel_level) |-> run_q[2] == (channel_level ? l2 : h2) * p1)
    else $error("uncorrected channel run wrong");
  a_dcc_on_high : assert property (
    calm && !dd_q && ct_q[5:4] == 2'b00 && $fell(channel_level) |-> run_q[2] == ((l2 + h2) * p1) >> 1)
    else $error("corrected channel high run wrong");
  a_tick_before_rise : assert property (
    calm && !ct_q[5] && channel_tick |=> $rose(stage2_level))
    else $error("channel tick not followed by stage two rise");
  c_divide : cover property (calm && !dd_q && $rose(channel_level));
  c_force : cover property (ct_q[3] && slo_q > 4'h7);
  c_hold : cover property (!ct_q[3] && slo_q > 4'h7);
endmodule // lcd_channel_divider_asserts
bind lcd_channel_divider lcd_channel_divider_asserts lcd_channel_divider_asserts_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .sync_n(sync_n),
  .stage1_level(stage1_level), .stage2_level(stage2_level),
  .channel_level(channel_level), .channel_tick(channel_tick),
  .next_stage1_level(next_stage1_level));
`default_nettype wire

// ---- testbench/lcd_rx_model.sv ----
// downstream clock receiver measuring low and high run lengths
`timescale 1ns/1ns
`default_nettype none
module lcd_rx_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       level,
  output logic      [9:0] lo_len,
  output logic      [9:0] hi_len
);
  logic       last_q;
  logic [9:0] run_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
      run_q <= 10'h000;
      lo_len <= 10'h000;
      hi_len <= 10'h000;
    end else begin
      last_q <= level;
      run_q <= (level != last_q) ? 10'h001 : run_q + 10'h001;
      if (level && !last_q) lo_len <= run_q;
      if (!level && last_q) hi_len <= run_q;
    end
  end
endmodule // lcd_rx_model
`default_nettype wire

// ---- testbench/lcd_channel_divider_tb_top.sv ----
// register and divider scenarios for the channel divider
`timescale 1ns/1ns
`default_nettype none
module lcd_channel_divider_tb_top;
  import lcd_pkg::*;
  logic                  pclk, presetn, psel, penable, pwrite, dist_tick, dist_level, sync_n;
  logic [LCD_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  pready, pslverr, er, stage1_level, stage2_level, channel_level;
  logic                  next_stage1_level;
  wire  [29:0]           lo;
  wire  [29:0]           hi;
  int                    n_wait;
  logic [9:0]            idx [6];
  logic [31:0]           rb [6];
  int                    fails, num_checks;
  lcd_channel_divider lcd_channel_divider_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dist_tick(dist_tick), .dist_level(dist_level),
    .sync_n(sync_n), .stage1_level(stage1_level), .stage2_level(stage2_level),
    .channel_level(channel_level), .channel_tick(), .next_stage1_level(next_stage1_level));
  // index 0 stage one, 1 channel, 2 next channel stage
  lcd_rx_model lcd_rx_model_inst [2:0] (.clk(pclk), .rst_n(presetn),
    .level({next_stage1_level, channel_level, stage1_level}), .lo_len(lo), .hi_len(hi));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) dist_level <= ~dist_level;
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic [9:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask
  task rdchk(input logic [9:0] a, input logic [31:0] e, input logic ee);
    apb(a, 1'b0, 32'h0);
    chk(rd, e);
    chk(32'(er), 32'(ee));
  endtask
  task tsync(input logic [31:0] c);
    @(posedge pclk);
    sync_n <= 1'b1;
    apb(LCD_IDX_CTRL, 1'b1, c);
    @(posedge pclk);
    sync_n <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, dist_level, paddr, pwdata} = '0;
    dist_tick = 1'b1;
    sync_n = 1'b1;
    idx = '{LCD_IDX_S1_CNT, LCD_IDX_PHASE, LCD_IDX_S2_CNT, LCD_IDX_CTRL, LCD_IDX_DCC, LCD_IDX_NXT_CNT};
    rb = '{32'hA5, 32'hA5, 32'hA5, 32'h25, 32'h1, 32'hA5};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(idx[i], 32'h0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      apb(idx[i], 1'b1, 32'hFFFFFFA5);
      rdchk(idx[i], rb[i], 1'b0);
    end
    rdchk(10'h100, 32'h0, 1'b1);
    // status is read only: a write is refused
    apb(LCD_IDX_STATUS, 1'b1, 32'h0);
    chk(32'(er), 32'h1);
    apb(LCD_IDX_S1_CNT, 1'b1, 32'h21);
    apb(LCD_IDX_S2_CNT, 1'b1, 32'h10);
    apb(LCD_IDX_NXT_CNT, 1'b1, 32'h32);
    apb(LCD_IDX_CTRL, 1'b1, 32'h0);
    repeat (700) @(posedge pclk);
    chk(32'(lo[9:0]), 32'h3);
    chk(32'(hi[9:0]), 32'h2);
    chk(32'(lo[19:10]), 32'hA);
    chk(32'(hi[19:10]), 32'h5);
    chk(32'(lo[29:20]), 32'h4);
    chk(32'(hi[29:20]), 32'h3);
    apb(LCD_IDX_CTRL, 1'b1, 32'h20);
    repeat (700) @(posedge pclk);
    chk(32'(lo[19:10]), 32'h3);
    chk(32'(hi[19:10]), 32'h2);
    apb(LCD_IDX_CTRL, 1'b1, 32'h10);
    repeat (700) @(posedge pclk);
    chk(32'(lo[9:0]) + 32'(hi[9:0]), 32'h2);
    apb(LCD_IDX_CTRL, 1'b1, 32'h0);
    apb(LCD_IDX_DCC, 1'b1, 32'h0);
    repeat (700) @(posedge pclk);
    chk(32'(hi[19:10]), 32'h7);
    chk(32'(lo[19:10]), 32'h8);
    tsync(32'h03);
    chk(32'({stage2_level, stage1_level}), 32'h3);
    // release: first high phase is high field 1 plus offset 5 plus one, after 5 cycles latency
    sync_n <= 1'b1;
    n_wait = 0;
    do begin
      @(posedge pclk);
      n_wait++;
    end while (stage1_level && n_wait < 40);
    chk(n_wait, 32'h1 + 32'h5 + 32'h1 + 32'h5);
    tsync(32'h0C);
    chk(32'(channel_level), 32'h1);
    tsync(32'h08);
    chk(32'(channel_level), 32'h0);
    chk(32'(lo[9:0]), 32'h3);
    sync_n <= 1'b1;
    report_and_stop();
  end
endmodule // lcd_channel_divider_tb_top
`default_nettype wire
